// ---- hw/key_sense_cell.sv ----
// one key-sense line: pin synchroniser and set-reset latch
`timescale 1ns/10ps
module key_sense_cell
	import keypad_io_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// keypad pin, low while pressed
	input wire logic line_n,
	// latch clear level from the control register
	input wire logic clear,
	// latched press
	output logic held
);

	logic sync1_ff;
	logic sync2_ff;
	logic held_ff;
	logic nxt_sync1;
	logic nxt_sync2;
	logic nxt_held;
	logic pressed;

	always_comb
	begin
		nxt_sync1 = line_n;
		nxt_sync2 = sync1_ff;
		// a pressed key pulls the line low, so invert
		pressed = ~sync2_ff; // R12
		// set wins over clear so a press during the clear is kept
		if (pressed)
		begin
			nxt_held = 1'b1; // R10
		end
		else if (clear)
		begin
			nxt_held = 1'b0; // R09
		end
		else
		begin
			nxt_held = held_ff; // R10
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1_ff <= 1'b1;
			sync2_ff <= 1'b1;
			held_ff <= 1'b0;
		end
		else
		begin
			sync1_ff <= nxt_sync1;
			sync2_ff <= nxt_sync2;
			held_ff <= nxt_held;
		end
	end

	assign held = held_ff;

endmodule // key_sense_cell

// ---- hw/keypad_io_pkg.sv ----
// shared constants and types for the remote keypad i/o port
package keypad_io_pkg;

	// bus geometry: word-only decoding, no lowest address bit
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int BYTE_W = 8;

	// register byte addresses
	localparam logic [23:0] CTRL_ADDR = 24'h100080;
	localparam logic [23:0] STATUS_ADDR = 24'h100082;

	// control register field positions
	localparam int CTRL_ROUTE_BIT = 0;
	localparam int CTRL_MEAS_BIT = 1;
	localparam int CTRL_MIC_BIT = 6;
	localparam int CTRL_RUN_BIT = 7;

	// control reset value and the bits a write may change
	localparam logic [7:0] CTRL_RESET = 8'h80;
	localparam logic [7:0] CTRL_WRITE_MASK = 8'hc3;

	// key status layout
	localparam int KEY_LINES = 7;
	localparam int STATUS_SPARE_BIT = 3;
	localparam int START_STOP_BIT = 7;
	localparam logic [7:0] STATUS_IDLE = 8'h00;
	localparam logic [7:0] UPPER_BYTE_FILL = 8'h00;

	// keypad line (one..six, start/stop) to status bit position
	localparam logic [2:0] LINE_BIT [0:6] = '{3'h2, 3'h1, 3'h0, 3'h4, 3'h5, 3'h6, 3'h7};

	// status patterns of each key, two bits per ordinary key
	localparam logic [7:0] KEY_LEFT = 8'h44;
	localparam logic [7:0] KEY_RIGHT = 8'h14;
	localparam logic [7:0] KEY_DOWN = 8'h06;
	localparam logic [7:0] KEY_UP = 8'h03;
	localparam logic [7:0] KEY_MENU = 8'h11;
	localparam logic [7:0] KEY_DATA = 8'h60;
	localparam logic [7:0] KEY_LEVEL = 8'h30;
	localparam logic [7:0] KEY_STORE = 8'h42;
	localparam logic [7:0] KEY_PRINT = 8'h22;
	localparam logic [7:0] KEY_CLEAR = 8'h41;
	localparam logic [7:0] KEY_SWEEP = 8'h05;
	localparam logic [7:0] KEY_AIDED = 8'h50;
	localparam logic [7:0] KEY_UNAIDED = 8'h21;
	localparam logic [7:0] KEY_START_STOP = 8'h80;

	// synchroniser depth for pins
	localparam int SYNC_STAGES = 2;

	// bus cycle states, gray along idle -> decode -> serve -> done
	typedef enum logic [1:0]
	{
		BUS_IDLE = 2'b00,
		BUS_DECODE = 2'b01,
		BUS_READ = 2'b11,
		BUS_DONE = 2'b10
	} bus_state_t;

endpackage

// ---- hw/remote_keypad_io_port.sv ----
// remote keypad i/o port: key status read port and audio/mic control write port
`timescale 1ns/10ps
//
// Operation
// R01: the key status port is read only by a word access and its upper byte carries no meaning.
// R02: status bits 0, 1, 2, 4, 5 and 6 idle at zero, each key sets its own pair, and bit 3 always reads zero.
// R03: status bit 7 goes to one only for the start/stop key or the foot switch.
// R04: data bits 0-7 are the odd byte and 8-15 the even byte, and decoding is word aligned with no lowest address bit.
// R05: the control port is written only by a word access and its upper byte is unused.
// R06: control bit 0 routes the generator to the chamber amplifier at zero and the remote speaker at one.
// R07: control bit 1 picks the chamber microphone at zero and the remote selected microphone at one.
// R08: control bit 6 drives the remote mic select line, probe at zero and reference at one.
// R09: control bit 7 rests at one and the key latches are cleared while software holds it at zero.
// R10: every key-sense line is held by a set-reset latch until the processor clears it.
// R11: latch outputs reach the data bus only through a buffer enabled during a key status read.
// R12: keypad lines are low when pressed and are inverted so a press reads as one.
// R13: keys map to status bit pairs as left 2+6, right 2+4, down 2+1, up 1+0, menu 0+4, data 5+6, level 4+5,
//      store 1+6, print 1+5, clear 0+6, sweep 2+0, aided 4+6, unaided 0+5, with 2+5 and 1+4 unused.
// R14: writes to control bits 2-5 and the upper byte do nothing, and bit 7 comes out of reset at one.
module remote_keypad_io_port
	import keypad_io_pkg::*;
(
	// clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// host system bus, asynchronous to CLK
	input wire logic [ADDR_W-1:1] ADDR,
	input wire logic AS_N,
	input wire logic RW,
	input wire logic UDS_N,
	input wire logic LDS_N,
	// host data bus, split two-way pin
	input wire logic [DATA_W-1:0] DATA_IN,
	output logic [DATA_W-1:0] DATA_OUT,
	output logic DATA_OE_N,
	// remote keypad pins, low while pressed
	input wire logic KEYPAD_LINE_ONE_N,
	input wire logic KEYPAD_LINE_TWO_N,
	input wire logic KEYPAD_LINE_THREE_N,
	input wire logic KEYPAD_LINE_FOUR_N,
	input wire logic KEYPAD_LINE_FIVE_N,
	input wire logic KEYPAD_LINE_SIX_N,
	input wire logic START_STOP_LINE_N,
	// audio and microphone steering
	output logic AUDIO_TO_REMOTE_SPEAKER,
	output logic MEAS_FROM_REMOTE_MIC,
	output logic REMOTE_MIC_SELECT,
	output logic KEY_LATCH_RUN
);

	// address, data, direction and both byte strobes cross as one word
	localparam int BUS_SYNC_W = (ADDR_W - 1) + DATA_W + 4;

	// bus synchroniser
	logic [BUS_SYNC_W-1:0] bus_s1_ff;
	logic [BUS_SYNC_W-1:0] bus_s2_ff;
	logic [BUS_SYNC_W-1:0] nxt_bus_s1;
	logic [BUS_SYNC_W-1:0] nxt_bus_s2;

	// synchronised bus fields
	logic [ADDR_W-1:1] addr_s;
	logic [DATA_W-1:0] data_s;
	logic as_act_s;
	logic rw_s;
	logic uds_act_s;
	logic lds_act_s;

	// bus cycle tracking
	bus_state_t state_ff;
	bus_state_t nxt_state;
	logic as_prev_ff;
	logic nxt_as_prev;
	logic [DATA_W-1:0] dout_ff;
	logic [DATA_W-1:0] nxt_dout;
	logic oe_n_ff;
	logic nxt_oe_n;

	// control register
	logic [BYTE_W-1:0] ctrl_ff;
	logic [BYTE_W-1:0] nxt_ctrl;

	// decode terms
	logic word_access;
	logic hit_ctrl;
	logic hit_status;
	logic cycle_start;
	// requests from the bus cycle: rd_open to the data path for the whole status read, ctrl_wr to the control register for one cycle
	logic rd_open;
	logic ctrl_wr;

	// keypad
	logic [KEY_LINES-1:0] lines_n;
	logic [KEY_LINES-1:0] held;
	logic [BYTE_W-1:0] status_vec;
	logic latch_clear;

	// bus pins cross into CLK through two flip-flops
	always_comb
	begin
		nxt_bus_s1 = {ADDR, DATA_IN, ~AS_N, RW, ~UDS_N, ~LDS_N};
		nxt_bus_s2 = bus_s1_ff;
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			bus_s1_ff <= '0;
			bus_s2_ff <= '0;
		end
		else
		begin
			bus_s1_ff <= nxt_bus_s1;
			bus_s2_ff <= nxt_bus_s2;
		end
	end

	assign addr_s = bus_s2_ff[BUS_SYNC_W-1 -: ADDR_W-1];
	assign data_s = bus_s2_ff[DATA_W+3:4];
	assign as_act_s = bus_s2_ff[3];
	assign rw_s = bus_s2_ff[2];
	assign uds_act_s = bus_s2_ff[1];
	assign lds_act_s = bus_s2_ff[0];

	// both byte strobes together make a word access; byte accesses are ignored
	assign word_access = uds_act_s & lds_act_s; // R01 R05

	// no lowest address bit: compare the word address only
	assign hit_ctrl = (addr_s == CTRL_ADDR[ADDR_W-1:1]); // R04
	assign hit_status = (addr_s == STATUS_ADDR[ADDR_W-1:1]); // R04

	// address and data must be stable one extra cycle before decode
	assign cycle_start = as_act_s & as_prev_ff;

	// keypad lines gathered in line order, start/stop last
	assign lines_n = {START_STOP_LINE_N, KEYPAD_LINE_SIX_N, KEYPAD_LINE_FIVE_N, KEYPAD_LINE_FOUR_N,
		KEYPAD_LINE_THREE_N, KEYPAD_LINE_TWO_N, KEYPAD_LINE_ONE_N};

	// clear is a level: while the run bit is low, latches stay empty except for keys still pressed
	assign latch_clear = ~ctrl_ff[CTRL_RUN_BIT]; // R09

	genvar gi;
	generate
		for (gi = 0; gi < KEY_LINES; gi = gi + 1)
		begin : g_key
			key_sense_cell u_cell
			(
				.clk(CLK),
				.rst_n(RST_N),
				.line_n(lines_n[gi]),
				.clear(latch_clear),
				.held(held[gi])
			);
			// line-to-bit wiring makes each ordinary key land on its own bit pair
			assign status_vec[LINE_BIT[gi]] = held[gi]; // R13 R02 R03
		end
	endgenerate

	// spare bit never set
	assign status_vec[STATUS_SPARE_BIT] = 1'b0; // R02

	// bus cycle tracking
	always_comb
	begin
		nxt_state = state_ff;
		nxt_as_prev = as_act_s;
		rd_open = 1'b0;
		ctrl_wr = 1'b0;
		// one access per strobe low period; done waits for the strobe to end
		case (state_ff)
			BUS_IDLE:
			begin
				if (cycle_start)
				begin
					nxt_state = BUS_DECODE;
				end
			end
			BUS_DECODE:
			begin
				if (!as_act_s)
				begin
					nxt_state = BUS_IDLE;
				end
				else if (rw_s && word_access && hit_status)
				begin
					// buffer opens only for a word read of the status port
					nxt_state = BUS_READ;
					rd_open = 1'b1; // R11
				end
				else if (!rw_s && word_access && hit_ctrl)
				begin
					ctrl_wr = 1'b1; // R05
					nxt_state = BUS_DONE;
				end
				else
				begin
					// byte access or unmapped: no answer, no change
					nxt_state = BUS_DONE; // R01 R05
				end
			end
			BUS_READ:
			begin
				if (!as_act_s)
				begin
					// leave through done so the read path stays gray coded
					nxt_state = BUS_DONE;
				end
				else
				begin
					// keep presenting live latch state until the strobe ends
					rd_open = 1'b1; // R11
				end
			end
			BUS_DONE:
			begin
				if (!as_act_s)
				begin
					nxt_state = BUS_IDLE;
				end
			end
			default:
			begin
				nxt_state = BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			state_ff <= BUS_IDLE;
			as_prev_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			as_prev_ff <= nxt_as_prev;
		end
	end

	// read data path: the buffer drives only while a status read stands
	always_comb
	begin
		nxt_oe_n = ~rd_open; // R11
		// bus released: no stale data left behind the buffer
		nxt_dout = {UPPER_BYTE_FILL, STATUS_IDLE};
		if (rd_open)
		begin
			// refreshed every cycle, so a press during the read still shows
			// status rides the odd byte; even byte carries no meaning
			nxt_dout = {UPPER_BYTE_FILL, status_vec}; // R01 R04
		end
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			dout_ff <= '0;
			oe_n_ff <= 1'b1;
		end
		else
		begin
			dout_ff <= nxt_dout;
			oe_n_ff <= nxt_oe_n;
		end
	end

	// control register: only the routing, mic and run bits take a write
	always_comb
	begin
		nxt_ctrl = ctrl_ff;
		if (ctrl_wr)
		begin
			// spare bits keep their zero, so they never read back set
			nxt_ctrl = (ctrl_ff & ~CTRL_WRITE_MASK) | (data_s[BYTE_W-1:0] & CTRL_WRITE_MASK); // R05 R14
		end
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			// run bit starts high so the latches are not held clear
			ctrl_ff <= CTRL_RESET; // R14
		end
		else
		begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	// outputs straight from registers
	assign DATA_OUT = dout_ff;
	assign DATA_OE_N = oe_n_ff; // R11
	assign AUDIO_TO_REMOTE_SPEAKER = ctrl_ff[CTRL_ROUTE_BIT]; // R06
	assign MEAS_FROM_REMOTE_MIC = ctrl_ff[CTRL_MEAS_BIT]; // R07
	assign REMOTE_MIC_SELECT = ctrl_ff[CTRL_MIC_BIT]; // R08
	assign KEY_LATCH_RUN = ctrl_ff[CTRL_RUN_BIT]; // R09

endmodule // remote_keypad_io_port

// ---- sim/keypad_port_props.sv ----
// concurrent checks on the keypad i/o port pins
`timescale 1ns/10ps
module keypad_port_props
	import keypad_io_pkg::*;
(
	// clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// host bus
	input wire logic [ADDR_W-1:1] ADDR,
	input wire logic AS_N,
	input wire logic RW,
	input wire logic UDS_N,
	input wire logic LDS_N,
	input wire logic [DATA_W-1:0] DATA_IN,
	input wire logic [DATA_W-1:0] DATA_OUT,
	input wire logic DATA_OE_N,
	// keypad
	input wire logic KEYPAD_LINE_ONE_N,
	input wire logic START_STOP_LINE_N,
	// steering
	input wire logic AUDIO_TO_REMOTE_SPEAKER,
	input wire logic MEAS_FROM_REMOTE_MIC,
	input wire logic REMOTE_MIC_SELECT,
	input wire logic KEY_LATCH_RUN
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	sequence rd_stat;
		$fell(AS_N) && RW && !UDS_N && !LDS_N && ADDR == STATUS_ADDR[23:1] ##1 (!AS_N)[*4];
	endsequence
	sequence wr_ctrl;
		$fell(AS_N) && !RW && !UDS_N && !LDS_N && ADDR == CTRL_ADDR[23:1] ##1 (!AS_N && $stable(DATA_IN))[*4];
	endsequence
	a_read_drive: assert property (rd_stat |=> !DATA_OE_N)
		else $error("status read not driven");
	a_oe_release: assert property ($rose(AS_N) |-> ##[1:4] DATA_OE_N)
		else $error("data bus not released");
	a_idle_quiet: assert property (DATA_OE_N |-> DATA_OUT == 16'h0000)
		else $error("data out not quiet");
	a_upper_zero: assert property (!DATA_OE_N |-> DATA_OUT[15:8] == UPPER_BYTE_FILL)
		else $error("upper byte not filled");
	a_spare_zero: assert property (!DATA_OE_N |-> !DATA_OUT[STATUS_SPARE_BIT])
		else $error("spare status bit set");
	a_write_route: assert property (wr_ctrl |=> AUDIO_TO_REMOTE_SPEAKER == DATA_IN[0] &&
		MEAS_FROM_REMOTE_MIC == DATA_IN[1])
		else $error("route bits wrong");
	a_write_mic: assert property (wr_ctrl |=> REMOTE_MIC_SELECT == DATA_IN[6] && KEY_LATCH_RUN == DATA_IN[7])
		else $error("mic or run bit wrong");
	a_byte_ignored: assert property ((!AS_N && (UDS_N || LDS_N))[*7] |-> DATA_OE_N && $stable({AUDIO_TO_REMOTE_SPEAKER,
		MEAS_FROM_REMOTE_MIC, REMOTE_MIC_SELECT, KEY_LATCH_RUN}))
		else $error("byte access honoured");
	a_stop_seen: assert property ((!START_STOP_LINE_N)[*6] ##0 !DATA_OE_N |-> DATA_OUT[START_STOP_BIT])
		else $error("start/stop press missing");
	a_line_one_seen: assert property ((!KEYPAD_LINE_ONE_N)[*6] ##0 !DATA_OE_N |-> DATA_OUT[2])
		else $error("line one press missing");
endmodule // keypad_port_props
bind remote_keypad_io_port keypad_port_props chk (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .AS_N(AS_N), .RW(RW),
	.UDS_N(UDS_N), .LDS_N(LDS_N), .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N),
	.KEYPAD_LINE_ONE_N(KEYPAD_LINE_ONE_N), .START_STOP_LINE_N(START_STOP_LINE_N),
	.AUDIO_TO_REMOTE_SPEAKER(AUDIO_TO_REMOTE_SPEAKER), .MEAS_FROM_REMOTE_MIC(MEAS_FROM_REMOTE_MIC),
	.REMOTE_MIC_SELECT(REMOTE_MIC_SELECT), .KEY_LATCH_RUN(KEY_LATCH_RUN));

// ---- sim/keypad_press_model.sv ----
// passive remote keypad: key pattern to low-active lines
`timescale 1ns/10ps
module keypad_press_model
	import keypad_io_pkg::*;
(
	// pattern of keys held, status layout
	input wire logic [7:0] press,
	// lines pulled up, grounded while pressed
	output logic [KEY_LINES-1:0] lines_n
);
	always_comb
	begin
		for (int i = 0; i < KEY_LINES; i++)
		begin
			lines_n[i] = !press[LINE_BIT[i]];
		end
	end
endmodule // keypad_press_model

// ---- sim/tb_remote_keypad_io_port.sv ----
// self-checking bench for the keypad i/o port
`timescale 1ns/10ps
module tb_remote_keypad_io_port
	import keypad_io_pkg::*;
;
	logic clk, rst_n, as_n, rw, uds_n, lds_n, oe_n, audio, meas, mic, run, qoe;
	logic [ADDR_W-1:1] addr;
	logic [15:0] data_in, data_out, q, d;
	logic [7:0] press;
	logic [6:0] lines_n;
	int fail_count, checks_done;
	wire [15:0] ctrl_pins = {12'h000, run, mic, meas, audio};
	logic [7:0] keys [14] = '{KEY_LEFT, KEY_RIGHT, KEY_DOWN, KEY_UP, KEY_MENU, KEY_DATA, KEY_LEVEL, KEY_STORE,
		KEY_PRINT, KEY_CLEAR, KEY_SWEEP, KEY_AIDED, KEY_UNAIDED, KEY_START_STOP};
	logic [15:0] corner [3] = '{16'hff3c, 16'h0041, 16'h00c3};
	remote_keypad_io_port dut (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .AS_N(as_n), .RW(rw), .UDS_N(uds_n),
		.LDS_N(lds_n), .DATA_IN(data_in), .DATA_OUT(data_out), .DATA_OE_N(oe_n),
		.KEYPAD_LINE_ONE_N(lines_n[0]), .KEYPAD_LINE_TWO_N(lines_n[1]), .KEYPAD_LINE_THREE_N(lines_n[2]),
		.KEYPAD_LINE_FOUR_N(lines_n[3]), .KEYPAD_LINE_FIVE_N(lines_n[4]), .KEYPAD_LINE_SIX_N(lines_n[5]),
		.START_STOP_LINE_N(lines_n[6]), .AUDIO_TO_REMOTE_SPEAKER(audio), .MEAS_FROM_REMOTE_MIC(meas),
		.REMOTE_MIC_SELECT(mic), .KEY_LATCH_RUN(run));
	keypad_press_model pad (.press(press), .lines_n(lines_n));
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	function automatic logic [15:0] ctrl_exp(input logic [15:0] v);
		return {12'h000, v[7], v[6], v[1], v[0]};
	endfunction
	function automatic logic [15:0] stat_exp(input logic [7:0] k);
		return {8'h00, k & 8'hf7};
	endfunction
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fail_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one bus cycle with the given byte strobes; no acknowledge exists, so the answer is taken at a fixed point
	task automatic bus(input logic [23:0] a, input logic wr, input logic [1:0] ds_n, input logic [15:0] v);
		@(posedge clk);
		addr <= a[23:1];
		rw <= !wr;
		{uds_n, lds_n} <= ds_n;
		data_in <= v;
		as_n <= 1'b0;
		repeat (7) @(posedge clk);
		@(negedge clk);
		q = data_out;
		qoe = oe_n;
		@(posedge clk);
		as_n <= 1'b1;
		{uds_n, lds_n} <= 2'b11;
		data_in <= ~v;
		repeat (4) @(posedge clk);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		{rst_n, as_n, rw, uds_n, lds_n} = 5'b01111;
		addr = '0;
		data_in = '0;
		press = '0;
		fail_count = 0;
		checks_done = 0;
		void'($urandom(32'h46441fa0));
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
		check(ctrl_pins, 16'h0008);
		check({15'h0000, oe_n}, 16'h0001);
		bus(STATUS_ADDR, 1'b0, 2'b00, 16'h0000);
		check(q, 16'h0000);
		$display("test reset done");
		foreach (keys[i])
		begin
			press <= keys[i];
			repeat (4) @(posedge clk);
			bus(STATUS_ADDR, 1'b0, 2'b00, 16'h0000);
			check(q, stat_exp(keys[i]));
			press <= 8'h00;
			bus(STATUS_ADDR, 1'b0, 2'b00, 16'h0000);
			check(q, stat_exp(keys[i]));
			bus(CTRL_ADDR, 1'b1, 2'b00, 16'h0000);
			bus(CTRL_ADDR, 1'b1, 2'b00, 16'h0080);
			bus(STATUS_ADDR, 1'b0, 2'b00, 16'h0000);
			check(q, 16'h0000);
		end
		$display("test keys done");
		for (int n = 0; n < 10; n++)
		begin
			d = (n < 3) ? corner[n] : 16'($urandom());
			bus(CTRL_ADDR, 1'b1, 2'b00, d);
			check(ctrl_pins, ctrl_exp(d));
		end
		bus(CTRL_ADDR, 1'b1, 2'b00, 16'h0080);
		$display("test control done");
		press <= KEY_DATA;
		for (int n = 0; n < 4; n++)
		begin
			bus(n < 2 ? STATUS_ADDR : (n == 2 ? CTRL_ADDR : 24'h100084), 1'b0, n[1] ? 2'b00 : {n[0], !n[0]}, 16'h0000);
			check({qoe, q[14:0]}, 16'h8000);
			bus(n < 2 ? CTRL_ADDR : STATUS_ADDR, 1'b1, n[1] ? 2'b00 : {n[0], !n[0]}, 16'h0041);
			check(ctrl_pins, 16'h0008);
		end
		$display("test refusals done");
		final_report();
	end
	initial
	begin
		#100000;
		fail_count++;
		final_report();
	end
endmodule // tb_remote_keypad_io_port
